//--- testbench/testbench.sv
// bench for the priority map and unknown-destination forwarding registers
// assumes the design package is compiled first; the bench drives every port itself
`timescale 1ns/1ps
module testbench;
  import switch_prio_pkg::*;

  logic                 clk, reset_in_n, ioSupply18, cyc, stb, we, ack;
  logic [ADR_W-1:0]     adr;
  logic [3:0]           sel;
  logic [DAT_W-1:0]     datI, datO;
  logic                 frameValid, frameTagged, queueValid;
  logic [TAG_W-1:0]     tagPrio;
  logic [PRIO_W-1:0]    portPrio, queuePrio;
  logic                 lookupValid, lookupMiss, egressValid;
  logic [NUM_PORTS-1:0] lookupPorts, floodPorts, egressPorts;
  logic [NUM_LEDP-1:0]  ledAutoSel, cpuLedOne, cpuLedZero, speed100, linkUp;
  logic [NUM_LEDP-1:0]  activity, fullDuplex, ledOne, ledZero;
  logic [DRV_W-1:0]     padDrive;
  int                   failures, checks_done;

  switch_priority_map_and_unknown_fwd i_dut (
    .clk(clk), .reset_in_n(reset_in_n), .ioSupply18(ioSupply18),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
    .frameValid(frameValid), .frameTagged(frameTagged), .tagPrio(tagPrio),
    .portPrio(portPrio), .queueValid(queueValid), .queuePrio(queuePrio),
    .lookupValid(lookupValid), .lookupMiss(lookupMiss), .lookupPorts(lookupPorts),
    .floodPorts(floodPorts), .egressValid(egressValid), .egressPorts(egressPorts),
    .ledAutoSel(ledAutoSel), .cpuLedOne(cpuLedOne), .cpuLedZero(cpuLedZero),
    .speed100(speed100), .linkUp(linkUp), .activity(activity), .fullDuplex(fullDuplex),
    .port_led_one(ledOne), .port_led_zero(ledZero), .padDrive(padDrive)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic print_verdict;
    if (failures == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // one classic wishbone cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [ADR_W-1:0] a, input logic [3:0] s,
                     input logic [15:0] d, output logic [DAT_W-1:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    datI <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    check(ack, 1'b1, "bus ack");
  endtask : bus

  task automatic wr(input logic [ADR_W-1:0] a, input logic [3:0] s, input logic [15:0] d);
    logic [DAT_W-1:0] q;
    bus(1'b1, a, s, d, q);
  endtask : wr

  task automatic rd(input logic [ADR_W-1:0] a, input logic [15:0] exp);
    logic [DAT_W-1:0] q;
    bus(1'b0, a, 4'h3, 16'h0000, q);
    check(q, {16'h0000, exp}, "read data");
  endtask : rd

  task automatic do_reset(input logic s);
    @(posedge clk);
    ioSupply18 <= s;
    reset_in_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_in_n <= 1'b1;
  endtask : do_reset

  task automatic frame(input logic tg, input logic [2:0] t, input logic [1:0] pp,
                       input logic [1:0] exp);
    @(posedge clk);
    frameValid <= 1'b1;
    frameTagged <= tg;
    tagPrio <= t;
    portPrio <= pp;
    @(posedge clk);
    frameValid <= 1'b0;
    @(posedge clk);
    check(queueValid, 1'b1, "queue valid");
    check(queuePrio, exp, "queue prio");
  endtask : frame

  task automatic lookup(input logic miss, input logic [2:0] known, input logic [2:0] flood,
                        input logic [2:0] exp);
    @(posedge clk);
    lookupValid <= 1'b1;
    lookupMiss <= miss;
    lookupPorts <= known;
    floodPorts <= flood;
    @(posedge clk);
    lookupValid <= 1'b0;
    @(posedge clk);
    check(egressValid, 1'b1, "egress valid");
    check(egressPorts, exp, "egress ports");
  endtask : lookup

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic test_reset_values(input logic s);
    rd(VPM_ADDR, 16'hfa50);
    rd(LUF_ADDR, s ? 16'h0847 : 16'h0827);
    check(padDrive, s ? 2'h2 : 2'h1, "drive reset");
  endtask : test_reset_values

  task automatic test_prio_map;
    logic [15:0] m;
    m = 16'h4e1b;
    wr(VPM_ADDR, 4'h3, m);
    for (int t = 0; t < 8; t++) begin
      frame(1'b1, t[2:0], 2'h0, m[2*t +: 2]);
    end
    frame(1'b0, 3'h7, 2'h2, 2'h2);
  endtask : test_prio_map

  task automatic test_unknown_fwd;
    logic [2:0] mk;
    lookup(1'b1, 3'h0, 3'h5, 3'h5);
    for (int i = 0; i < 3; i++) begin
      mk = 3'h1 << i;
      wr(LUF_ADDR, 4'h3, {8'h08, 5'h14, mk});
      lookup(1'b1, 3'h2, 3'h6, mk);
    end
    lookup(1'b0, 3'h2, 3'h6, 3'h2);
    rd(LUF_ADDR, 16'h08a4);
  endtask : test_unknown_fwd

  task automatic test_led_drive;
    logic [1:0] m, one, zero;
    ledAutoSel <= 2'b11;
    speed100 <= 2'b01;
    linkUp <= 2'b11;
    activity <= 2'b10;
    fullDuplex <= 2'b11;
    cpuLedOne <= 2'b01;
    cpuLedZero <= 2'b00;
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      wr(LUF_ADDR, 4'h3, {6'h02, m, 1'b0, m, 5'h07});
      rd(LUF_ADDR, {6'h02, m, 1'b0, m, 5'h07});
      check(padDrive, m, "pad drive");
      one = (m == 2'h0) ? speed100 : (m == 2'h1) ? activity : fullDuplex;
      zero = m[0] ? linkUp : (linkUp & ~activity);
      check(ledOne, one, "led one");
      check(ledZero, zero, "led zero");
    end
    ledAutoSel <= 2'b01;
    repeat (3) @(posedge clk);
    check(ledOne, {cpuLedOne[1], fullDuplex[0]}, "led one cpu");
    check(ledZero, {cpuLedZero[1], linkUp[0]}, "led zero cpu");
  endtask : test_led_drive

  task automatic test_bus_edges;
    wr(8'h3c, 4'h3, 16'hffff);
    rd(8'h3c, 16'h0000);
    wr(LUF_ADDR, 4'h2, 16'h0000);
    rd(LUF_ADDR, 16'h0067);
    rd(VPM_ADDR, 16'h4e1b);
  endtask : test_bus_edges

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    {reset_in_n, ioSupply18, cyc, stb, we, adr, sel, datI} = '0;
    {frameValid, frameTagged, tagPrio, portPrio} = '0;
    {lookupValid, lookupMiss, lookupPorts, floodPorts} = '0;
    {ledAutoSel, cpuLedOne, cpuLedZero, speed100, linkUp, activity, fullDuplex} = '0;
    failures = 0;
    checks_done = 0;
    do_reset(1'b0);
    test_reset_values(1'b0);
    test_prio_map;
    test_unknown_fwd;
    test_led_drive;
    test_bus_edges;
    do_reset(1'b1);
    test_reset_values(1'b1);
    print_verdict;
  end

  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    print_verdict;
  end

endmodule : testbench

//--- verilog/led_mode_mux.sv
// one port's pair of leds, automatic pattern or processor control
// assumes status inputs synchronous to clk, leds active high
`timescale 1ns/1ps
module led_mode_mux
  import switch_prio_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset_in_n,
  input  wire logic [LED_W-1:0] ledMode,
  input  wire logic             autoSel,
  input  wire logic             cpuLedOne,
  input  wire logic             cpuLedZero,
  input  wire logic             speed100,
  input  wire logic             linkUp,
  input  wire logic             activity,
  input  wire logic             fullDuplex,
  output logic                  ledOne,
  output logic                  ledZero
);

  logic next_ledOne;
  logic next_ledZero;
  logic linkAct;

  assign linkAct = linkUp & ~activity;

  always_comb begin
    next_ledOne  = cpuLedOne;
    next_ledZero = cpuLedZero;
    // (R7) automatic only when selected
    if (autoSel) begin
      // (R6) led pattern per mode
      unique case (ledMode)
        LED_SPD_LACT: begin
          next_ledOne  = speed100;
          next_ledZero = linkAct;
        end
        LED_ACT_LINK: begin
          next_ledOne  = activity;
          next_ledZero = linkUp;
        end
        LED_FDX_LACT: begin
          next_ledOne  = fullDuplex;
          next_ledZero = linkAct;
        end
        LED_FDX_LINK: begin
          next_ledOne  = fullDuplex;
          next_ledZero = linkUp;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_in_n) begin
      ledOne  <= 1'h0;
      ledZero <= 1'h0;
    end else begin
      ledOne  <= next_ledOne;
      ledZero <= next_ledZero;
    end
  end

endmodule : led_mode_mux

//--- verilog/switch_prio_pkg.sv
// constants for the priority map and unknown-destination forwarding registers
// assumes a classic wishbone slave with 32-bit data and one 200 MHz clock
// Summary of operation
// (R1) tags 7 and 6 take their queue from bits 15:14 and 13:12, both reset to 11.
// (R2) tags 5 and 4 take their queue from bits 11:10 and 9:8, both reset to 10.
// (R3) tags 3 and 2 take their queue from bits 7:6 and 5:4, both reset to 01.
// (R4) tags 1 and 0 take their queue from bits 3:2 and 1:0, both reset to 00.
// (R5) the led mode at bits 9:8 is read/write, resets to 00 and reads back the mode in use.
// (R6) led modes: 00 speed/link-act, 01 activity/link, 10 duplex/link-act, 11 duplex/link.
// (R7) the led mode drives a port's leds only while that port selects automatic control.
// (R8) with enable bit 7 set, unknown-destination frames go only to the masked ports.
// (R9) the port mask at bits 2:0 resets to 111 and covers unicast and multicast alike.
// (R10) mask bit 2 is port 3 (host port), bit 1 port 2, bit 0 port 1.
// (R11) bits 6:5 select 4/8/12/16 mA pad drive, reset 01 at 3.3/2.5 V and 10 at 1.8 V.
// (R12) with the enable clear, unknown-destination frames are flooded as usual.
package switch_prio_pkg;

  localparam int ADR_W     = 8;
  localparam int DAT_W     = 32;
  localparam int REG_W     = 16;
  localparam int PRIO_W    = 2;
  localparam int TAG_W     = 3;
  localparam int NUM_PORTS = 3;
  localparam int NUM_LEDP  = 2;

  // register indices and their byte addresses
  localparam logic [ADR_W-1:0] VPM_INDEX = 8'h0c;
  localparam logic [ADR_W-1:0] LUF_INDEX = 8'h0e;
  localparam logic [ADR_W-1:0] VPM_ADDR  = {VPM_INDEX[ADR_W-3:0], 2'h0};
  localparam logic [ADR_W-1:0] LUF_ADDR  = {LUF_INDEX[ADR_W-3:0], 2'h0};

  // priority map reset: 11 11 10 10 01 01 00 00
  localparam logic [REG_W-1:0] VPM_RESET = 16'hfa50;

  // control register fields
  localparam int RSVH_LSB = 10;
  localparam int RSVH_W   = 6;
  localparam int LED_LSB  = 8;
  localparam int LED_W    = 2;
  localparam int UEN_BIT  = 7;
  localparam int DRV_LSB  = 5;
  localparam int DRV_W    = 2;
  localparam int RSVL_LSB = 3;
  localparam int RSVL_W   = 2;
  localparam int MASK_LSB = 0;

  localparam logic [RSVH_W-1:0]    RSVH_RESET = 6'h02;
  localparam logic [LED_W-1:0]     LED_RESET  = 2'h0;
  localparam logic                 UEN_RESET  = 1'h0;
  localparam logic [DRV_W-1:0]     DRV_RST_HI = 2'h1;
  localparam logic [DRV_W-1:0]     DRV_RST_LO = 2'h2;
  localparam logic [RSVL_W-1:0]    RSVL_RESET = 2'h0;
  localparam logic [NUM_PORTS-1:0] MASK_RESET = 3'h7;

  // led display modes
  localparam logic [LED_W-1:0] LED_SPD_LACT = 2'h0;
  localparam logic [LED_W-1:0] LED_ACT_LINK = 2'h1;
  localparam logic [LED_W-1:0] LED_FDX_LACT = 2'h2;
  localparam logic [LED_W-1:0] LED_FDX_LINK = 2'h3;

  localparam logic [DAT_W-REG_W-1:0] DAT_PAD = 16'h0000;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h1,
    BUS_ACK  = 2'h2
  } bus_state_t;

endpackage : switch_prio_pkg

//--- verilog/switch_priority_map_and_unknown_fwd.sv
// priority map and unknown-destination forwarding registers with their consumers
// assumes a classic wishbone master and forwarding-engine inputs synchronous to clk
`timescale 1ns/1ps
module switch_priority_map_and_unknown_fwd
  import switch_prio_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 reset_in_n,
  input  wire logic                 ioSupply18,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [ADR_W-1:0]     wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [DAT_W-1:0]     wb_dat_i,
  output logic      [DAT_W-1:0]     wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 frameValid,
  input  wire logic                 frameTagged,
  input  wire logic [TAG_W-1:0]     tagPrio,
  input  wire logic [PRIO_W-1:0]    portPrio,
  output logic                      queueValid,
  output logic      [PRIO_W-1:0]    queuePrio,
  input  wire logic                 lookupValid,
  input  wire logic                 lookupMiss,
  input  wire logic [NUM_PORTS-1:0] lookupPorts,
  input  wire logic [NUM_PORTS-1:0] floodPorts,
  output logic                      egressValid,
  output logic      [NUM_PORTS-1:0] egressPorts,
  input  wire logic [NUM_LEDP-1:0]  ledAutoSel,
  input  wire logic [NUM_LEDP-1:0]  cpuLedOne,
  input  wire logic [NUM_LEDP-1:0]  cpuLedZero,
  input  wire logic [NUM_LEDP-1:0]  speed100,
  input  wire logic [NUM_LEDP-1:0]  linkUp,
  input  wire logic [NUM_LEDP-1:0]  activity,
  input  wire logic [NUM_LEDP-1:0]  fullDuplex,
  output logic      [NUM_LEDP-1:0]  port_led_one,
  output logic      [NUM_LEDP-1:0]  port_led_zero,
  output logic      [DRV_W-1:0]     padDrive
);

  ////////////////////////////////////////////////////////////////////////////////
  // register bus

  bus_state_t             busState;
  bus_state_t             next_busState;
  logic [REG_W-1:0]       vlan_priority_map;
  logic [REG_W-1:0]       next_vlan_priority_map;
  logic [REG_W-1:0]       led_unknown_fwd_drive_ctrl;
  logic [REG_W-1:0]       next_led_unknown_fwd_drive_ctrl;
  logic [DAT_W-1:0]       next_wbDat;
  logic [REG_W-1:0]       laneMask;
  logic                   take;
  logic                   hitVpm;
  logic                   hitLuf;
  logic [LED_W-1:0]       ledMode;
  logic                   unkEnable;
  logic [NUM_PORTS-1:0]   unkMask;
  logic [DRV_W-1:0]       drvReset;

  assign take     = wb_cyc_i & wb_stb_i & (busState == BUS_IDLE);
  assign hitVpm   = (wb_adr_i == VPM_ADDR);
  assign hitLuf   = (wb_adr_i == LUF_ADDR);
  assign laneMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wb_ack_o = (busState == BUS_ACK);

  assign ledMode   = led_unknown_fwd_drive_ctrl[LED_LSB +: LED_W];
  assign unkEnable = led_unknown_fwd_drive_ctrl[UEN_BIT];
  assign unkMask   = led_unknown_fwd_drive_ctrl[MASK_LSB +: NUM_PORTS];
  assign padDrive  = led_unknown_fwd_drive_ctrl[DRV_LSB +: DRV_W];
  // (R11) drive reset by supply
  assign drvReset  = ioSupply18 ? DRV_RST_LO : DRV_RST_HI;

  always_comb begin
    next_busState                   = busState;
    next_wbDat                      = wb_dat_o;
    next_vlan_priority_map          = vlan_priority_map;
    next_led_unknown_fwd_drive_ctrl = led_unknown_fwd_drive_ctrl;
    unique case (busState)
      BUS_IDLE: begin
        if (take) begin
          next_busState = BUS_ACK;
          next_wbDat    = {DAT_PAD, REG_W'(0)};
          if (wb_we_i) begin
            if (hitVpm) begin
              next_vlan_priority_map = (vlan_priority_map & ~laneMask)
                                     | (wb_dat_i[REG_W-1:0] & laneMask);
            end
            if (hitLuf) begin
              next_led_unknown_fwd_drive_ctrl = (led_unknown_fwd_drive_ctrl & ~laneMask)
                                              | (wb_dat_i[REG_W-1:0] & laneMask);
            end
          end else if (hitVpm) begin
            next_wbDat = {DAT_PAD, vlan_priority_map};
          end else if (hitLuf) begin
            // (R5) mode in use reads back
            next_wbDat = {DAT_PAD, led_unknown_fwd_drive_ctrl};
          end
        end
      end
      BUS_ACK: begin
        next_busState = BUS_IDLE;
      end
      default: begin
        next_busState = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_in_n) begin
      busState          <= BUS_IDLE;
      wb_dat_o          <= {DAT_PAD, REG_W'(0)};
      // (R1) (R2) (R3) (R4) map reset
      vlan_priority_map <= VPM_RESET;
      // (R5) (R8) (R9) (R11) control reset
      led_unknown_fwd_drive_ctrl <= {RSVH_RESET, LED_RESET, UEN_RESET, drvReset,
                                     RSVL_RESET, MASK_RESET};
    end else begin
      busState                   <= next_busState;
      wb_dat_o                   <= next_wbDat;
      vlan_priority_map          <= next_vlan_priority_map;
      led_unknown_fwd_drive_ctrl <= next_led_unknown_fwd_drive_ctrl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // tag priority to queue

  logic              next_queueValid;
  logic [PRIO_W-1:0] next_queuePrio;
  logic [PRIO_W-1:0] mapPrio;

  // (R1) (R2) (R3) (R4) field per tag value
  assign mapPrio = vlan_priority_map[{tagPrio, 1'h0} +: PRIO_W];

  always_comb begin
    next_queueValid = frameValid;
    next_queuePrio  = queuePrio;
    if (frameValid) begin
      next_queuePrio = frameTagged ? mapPrio : portPrio;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_in_n) begin
      queueValid <= 1'h0;
      queuePrio  <= PRIO_W'(0);
    end else begin
      queueValid <= next_queueValid;
      queuePrio  <= next_queuePrio;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // unknown-destination forwarding

  logic                 next_egressValid;
  logic [NUM_PORTS-1:0] next_egressPorts;

  always_comb begin
    next_egressValid = lookupValid;
    next_egressPorts = egressPorts;
    if (lookupValid) begin
      if (!lookupMiss) begin
        next_egressPorts = lookupPorts;
      end else if (unkEnable) begin
        // (R8) (R9) (R10) masked ports only
        next_egressPorts = unkMask;
      end else begin
        // (R12) ordinary flooding
        next_egressPorts = floodPorts;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_in_n) begin
      egressValid <= 1'h0;
      egressPorts <= NUM_PORTS'(0);
    end else begin
      egressValid <= next_egressValid;
      egressPorts <= next_egressPorts;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // port leds

  genvar p;
  generate
    for (p = 0; p < NUM_LEDP; p++) begin : gLed
      // (R6) (R7) per-port led drive
      led_mode_mux uLed (
        .clk        (clk),
        .reset_in_n       (reset_in_n),
        .ledMode    (ledMode),
        .autoSel    (ledAutoSel[p]),
        .cpuLedOne  (cpuLedOne[p]),
        .cpuLedZero (cpuLedZero[p]),
        .speed100   (speed100[p]),
        .linkUp     (linkUp[p]),
        .activity   (activity[p]),
        .fullDuplex (fullDuplex[p]),
        .ledOne     (port_led_one[p]),
        .ledZero    (port_led_zero[p])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_in_n);

  map_reset_a: assert property ($rose(reset_in_n) |-> vlan_priority_map == VPM_RESET) // R1
    else $error("priority map reset value wrong");

  tag_high_a: assert property (frameValid && frameTagged && tagPrio[2:1] == 2'h3 |=> // R1
      queuePrio == ($past(tagPrio[0]) ? $past(vlan_priority_map[15:14])
                               : $past(vlan_priority_map[13:12])))
    else $error("tag 7/6 queue wrong");

  tag_mid_a: assert property (frameValid && frameTagged && tagPrio[2:1] == 2'h2 |=> // R2
      queuePrio == ($past(tagPrio[0]) ? $past(vlan_priority_map[11:10])
                               : $past(vlan_priority_map[9:8])))
    else $error("tag 5/4 queue wrong");

  tag_low_a: assert property (frameValid && frameTagged && tagPrio[2:1] == 2'h1 |=> // R3
      queuePrio == ($past(tagPrio[0]) ? $past(vlan_priority_map[7:6])
                               : $past(vlan_priority_map[5:4])))
    else $error("tag 3/2 queue wrong");

  tag_zero_a: assert property (frameValid && frameTagged && tagPrio[2:1] == 2'h0 |=> // R4
      queuePrio == ($past(tagPrio[0]) ? $past(vlan_priority_map[3:2])
                               : $past(vlan_priority_map[1:0])))
    else $error("tag 1/0 queue wrong");

  led_readback_a: assert property (take && !wb_we_i && hitLuf |=> // R5
      wb_ack_o && wb_dat_o[9:8] == ledMode)
    else $error("led mode readback wrong");

  led_actlink_a: assert property (ledAutoSel[0] && ledMode == LED_ACT_LINK |=> // R6
      port_led_one[0] == $past(activity[0]) && port_led_zero[0] == $past(linkUp[0]))
    else $error("led mode 01 pattern wrong");

  led_manual_a: assert property (!ledAutoSel[1] |=> // R7
      port_led_one[1] == $past(cpuLedOne[1]) && port_led_zero[1] == $past(cpuLedZero[1]))
    else $error("manual led not followed");

  unk_mask_a: assert property (lookupValid && lookupMiss && unkEnable |=> // R8
      egressValid && egressPorts == $past(unkMask))
    else $error("unknown frame not sent to mask");

  mask_reset_a: assert property ($rose(reset_in_n) |-> unkMask == 3'h7 && !unkEnable) // R9
    else $error("unknown mask reset wrong");

  drive_reset_a: assert property ($rose(reset_in_n) |-> // R11
      padDrive == ($past(ioSupply18) ? 2'h2 : 2'h1))
    else $error("drive strength reset wrong");

  flood_a: assert property (lookupValid && lookupMiss && !unkEnable |=> // R12
      egressPorts == $past(floodPorts))
    else $error("flooding not used");

  ack_pulse_a: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one cycle");

  tag_seven_c: cover property (frameValid && frameTagged && tagPrio == 3'h7);
  unk_fwd_c: cover property (lookupValid && lookupMiss && unkEnable);
  led_auto_c: cover property (ledAutoSel[0] && ledMode == LED_FDX_LINK);

endmodule : switch_priority_map_and_unknown_fwd
